// ---- verilog/pct_timer.sv ----
// pulse counter timer: byte timer, word timer, captures, edge input, APB registers
// Function
// R1: control bit 7 starts, stops, reads run
// R2: bit 6 picks reload or single pass
// R3: bit 5 timeout flag, write one clears
// R4: software clears timeout before using timers
// R5: bits 4:3 divide clock by 1,2,4,8
// R6: bit 2 enables capture interrupt
// R7: bit 1 enables timeout interrupt
// R8: bit 0 routes byte output to pin
// R9: first prescaled tick may be short
// R10: read-modify-write must not write back flags
// R11: byte high/low capture registers, read only
// R12: word capture bytes, read only
// R13: word timer hold bytes, read/write
// R14: byte timer high/low hold registers
// R15: edge detector, pin and polarity select
// R16: glitch filter drops narrow pulses
// R17: idle byte output is inverse of D1
// R18: word timeout interrupt when masked in
// R19: word pin carries timer or port
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
module pct_timer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic edge_input_pin_a,
   input wire logic edge_input_pin_b,
   input wire logic byte_port_data,
   input wire logic word_port_data,
   output logic byte_timer_pin,
   output logic word_timer_pin,
   // interrupt
   output logic irq
);
   logic bt_run_r, bt_single_r, bt_tout_r, bt_cap_ie_r, bt_tout_ie_r, byte_pin_route_r;
   logic [1:0] byte_prescale_select_r;
   logic wt_run_r, wt_single_r, wt_tout_r, wt_tout_ie_r, word_pin_route_r;
   logic [7:0] common_r;
   logic [7:0] bt_lo_hold_r, bt_hi_hold_r, wt_lo_hold_r, wt_hi_hold_r;
   logic [7:0] bt_lo_cap_r, bt_hi_cap_r;
   logic [15:0] wt_cap_r;
   logic [7:0] bt_cnt_r;
   logic [15:0] wt_cnt_r;
   logic bt_out_r, wt_out_r;
   logic [2:0] presc_r;
   logic [2:0] irq_stat_r, irq_en_r, irq_set;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic wr, rd_setup, addr_ok;
   logic [5:0] idx;
   logic tick, demod, bt_term, wt_term, edge_pulse, edge_level, bt_cap_ev;

   assign idx = paddr[7:2];
   assign wr = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign demod = common_r[pct_pkg::DEMOD_BIT];
   // slave never stalls; read data is captured in the setup cycle
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   always_comb begin
      addr_ok = (paddr[1:0] == 2'h0);
      unique case (idx)
         pct_pkg::IDX_BT_CTRL, pct_pkg::IDX_COMMON, pct_pkg::IDX_WT_CTRL,
         pct_pkg::IDX_BT_LO_HOLD, pct_pkg::IDX_BT_HI_HOLD, pct_pkg::IDX_WT_LO_HOLD,
         pct_pkg::IDX_WT_HI_HOLD, pct_pkg::IDX_WT_LO_CAP, pct_pkg::IDX_WT_HI_CAP,
         pct_pkg::IDX_BT_LO_CAP, pct_pkg::IDX_BT_HI_CAP, pct_pkg::IDX_IRQ_STATUS,
         pct_pkg::IDX_IRQ_CLEAR, pct_pkg::IDX_IRQ_ENABLE: ;
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (rd_setup) begin
         pslverr_r <= !addr_ok;
         prdata_r <= 32'h0000_0000;
         unique case (idx)
            pct_pkg::IDX_BT_CTRL: prdata_r[7:0] <= {bt_run_r, bt_single_r, bt_tout_r, // R1
               byte_prescale_select_r, bt_cap_ie_r, bt_tout_ie_r, byte_pin_route_r};
            pct_pkg::IDX_COMMON: prdata_r[7:0] <= common_r;
            pct_pkg::IDX_WT_CTRL: prdata_r[7:0] <= {wt_run_r, wt_single_r, wt_tout_r,
               3'h0, wt_tout_ie_r, word_pin_route_r};
            pct_pkg::IDX_BT_LO_HOLD: prdata_r[7:0] <= bt_lo_hold_r;
            pct_pkg::IDX_BT_HI_HOLD: prdata_r[7:0] <= bt_hi_hold_r;
            pct_pkg::IDX_WT_LO_HOLD: prdata_r[7:0] <= wt_lo_hold_r;
            pct_pkg::IDX_WT_HI_HOLD: prdata_r[7:0] <= wt_hi_hold_r;
            pct_pkg::IDX_WT_LO_CAP: prdata_r[7:0] <= wt_cap_r[7:0]; // R12
            pct_pkg::IDX_WT_HI_CAP: prdata_r[7:0] <= wt_cap_r[15:8]; // R12
            pct_pkg::IDX_BT_LO_CAP: prdata_r[7:0] <= bt_lo_cap_r; // R11
            pct_pkg::IDX_BT_HI_CAP: prdata_r[7:0] <= bt_hi_cap_r; // R11
            pct_pkg::IDX_IRQ_STATUS: prdata_r[2:0] <= irq_stat_r;
            pct_pkg::IDX_IRQ_ENABLE: prdata_r[2:0] <= irq_en_r;
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // control registers; a terminal count in single pass clears run unless software writes it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bt_run_r <= 1'b0;
         bt_single_r <= 1'b0;
         byte_prescale_select_r <= 2'h0;
         bt_cap_ie_r <= 1'b0;
         bt_tout_ie_r <= 1'b0;
         byte_pin_route_r <= 1'b0;
      end else if (wr && addr_ok && idx == pct_pkg::IDX_BT_CTRL) begin
         bt_run_r <= pwdata[pct_pkg::RUN_BIT]; // R1
         bt_single_r <= pwdata[pct_pkg::SINGLE_BIT]; // R2
         byte_prescale_select_r <= pwdata[pct_pkg::CLK_HI_BIT:pct_pkg::CLK_LO_BIT]; // R5
         bt_cap_ie_r <= pwdata[pct_pkg::CAP_IE_BIT]; // R6
         bt_tout_ie_r <= pwdata[pct_pkg::TOUT_IE_BIT]; // R7
         byte_pin_route_r <= pwdata[pct_pkg::ROUTE_BIT]; // R8
      end else if (bt_term && bt_single_r) begin
         bt_run_r <= 1'b0; // R2
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wt_run_r <= 1'b0;
         wt_single_r <= 1'b0;
         wt_tout_ie_r <= 1'b0;
         word_pin_route_r <= 1'b0;
      end else if (wr && addr_ok && idx == pct_pkg::IDX_WT_CTRL) begin
         wt_run_r <= pwdata[pct_pkg::RUN_BIT];
         wt_single_r <= pwdata[pct_pkg::SINGLE_BIT];
         wt_tout_ie_r <= pwdata[pct_pkg::TOUT_IE_BIT]; // R18
         word_pin_route_r <= pwdata[pct_pkg::ROUTE_BIT]; // R19
      end else if (wt_term && wt_single_r) begin
         wt_run_r <= 1'b0;
      end
   end

   // timeout flags: terminal count wins over a write-one clear (software must not write back a read 1)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bt_tout_r <= 1'b0;
         wt_tout_r <= 1'b0;
      end else begin
         if (bt_term) begin
            bt_tout_r <= 1'b1; // R3
         end else if (wr && addr_ok && idx == pct_pkg::IDX_BT_CTRL && pwdata[pct_pkg::TOUT_BIT]) begin
            bt_tout_r <= 1'b0; // R3 R10
         end
         if (wt_term) begin
            wt_tout_r <= 1'b1;
         end else if (wr && addr_ok && idx == pct_pkg::IDX_WT_CTRL && pwdata[pct_pkg::TOUT_BIT]) begin
            wt_tout_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         common_r <= pct_pkg::CTRL_RESET;
         bt_lo_hold_r <= pct_pkg::HOLD_RESET;
         bt_hi_hold_r <= pct_pkg::HOLD_RESET;
         wt_lo_hold_r <= pct_pkg::HOLD_RESET;
         wt_hi_hold_r <= pct_pkg::HOLD_RESET;
         irq_en_r <= pct_pkg::IRQ_RESET;
      end else if (wr && addr_ok) begin
         unique case (idx)
            pct_pkg::IDX_COMMON: common_r <= pwdata[7:0];
            pct_pkg::IDX_BT_LO_HOLD: bt_lo_hold_r <= pwdata[7:0]; // R14
            pct_pkg::IDX_BT_HI_HOLD: bt_hi_hold_r <= pwdata[7:0]; // R14
            pct_pkg::IDX_WT_LO_HOLD: wt_lo_hold_r <= pwdata[7:0]; // R13
            pct_pkg::IDX_WT_HI_HOLD: wt_hi_hold_r <= pwdata[7:0]; // R13
            pct_pkg::IDX_IRQ_ENABLE: irq_en_r <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // prescaler runs free, so the first tick after enable lands anywhere in its cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_r <= 3'h0;
      end else begin
         presc_r <= presc_r + 3'h1; // R9
      end
   end

   always_comb begin
      unique case (byte_prescale_select_r) // R5
         2'h0: tick = 1'b1;
         2'h1: tick = presc_r[0];
         2'h2: tick = &presc_r[1:0];
         2'h3: tick = &presc_r;
      endcase
   end

   pct_edge_filter u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .edge_input_pin_a(edge_input_pin_a),
      .edge_input_pin_b(edge_input_pin_b),
      .pin_sel(common_r[pct_pkg::PIN_SEL_BIT]),
      .edge_neg(common_r[pct_pkg::EDGE_NEG_BIT]),
      .width_sel(common_r[pct_pkg::FILT_HI_BIT:pct_pkg::FILT_LO_BIT]),
      .level(edge_level),
      .edge_pulse(edge_pulse)
   );

   // byte timer: transmit counts down through the hold values, demodulation counts up between edges
   assign bt_term = bt_run_r && tick && !(demod && edge_pulse)
      && (bt_cnt_r == (demod ? pct_pkg::BT_TERMINAL_UP : 8'h00));
   assign bt_cap_ev = bt_run_r && demod && edge_pulse;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bt_cnt_r <= 8'h00;
      end else if (!bt_run_r) begin
         bt_cnt_r <= demod ? 8'h00 : (common_r[pct_pkg::IDLE_LVL_BIT] ? bt_lo_hold_r : bt_hi_hold_r);
      end else if (bt_cap_ev) begin
         bt_cnt_r <= 8'h00;
      end else if (tick) begin
         if (demod) begin
            bt_cnt_r <= bt_cnt_r + 8'h01;
         end else if (bt_cnt_r == 8'h00) begin
            bt_cnt_r <= bt_out_r ? bt_lo_hold_r : bt_hi_hold_r; // R2
         end else begin
            bt_cnt_r <= bt_cnt_r - 8'h01;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bt_out_r <= 1'b1;
      end else if (!bt_run_r) begin
         bt_out_r <= !common_r[pct_pkg::IDLE_LVL_BIT]; // R17
      end else if (bt_term && !demod) begin
         bt_out_r <= !bt_out_r;
      end
   end

   // edge after a high stretch lands in the high capture, after a low stretch in the low one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bt_lo_cap_r <= 8'h00;
         bt_hi_cap_r <= 8'h00;
      end else if (bt_cap_ev) begin
         if (edge_level) begin
            bt_lo_cap_r <= bt_cnt_r; // R11
         end else begin
            bt_hi_cap_r <= bt_cnt_r; // R11
         end
      end
   end

   // word timer counts pclk down from its hold; an edge in demodulation snapshots it
   assign wt_term = wt_run_r && (wt_cnt_r == 16'h0000);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wt_cnt_r <= 16'h0000;
         wt_out_r <= 1'b0;
      end else if (!wt_run_r) begin
         wt_cnt_r <= {wt_hi_hold_r, wt_lo_hold_r};
      end else if (wt_term) begin
         wt_cnt_r <= {wt_hi_hold_r, wt_lo_hold_r};
         wt_out_r <= !wt_out_r;
      end else begin
         wt_cnt_r <= wt_cnt_r - 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wt_cap_r <= 16'h0000;
      end else if (wt_run_r && demod && edge_pulse) begin
         wt_cap_r <= wt_cnt_r; // R12
      end
   end

   assign byte_timer_pin = byte_pin_route_r ? bt_out_r : byte_port_data; // R8
   assign word_timer_pin = word_pin_route_r ? wt_out_r : word_port_data; // R19

   // interrupt status: sticky, set wins over the clear register
   always_comb begin
      irq_set = 3'h0;
      irq_set[pct_pkg::IRQ_BT_TOUT] = bt_term && bt_tout_ie_r; // R7
      irq_set[pct_pkg::IRQ_BT_CAP] = bt_cap_ev && bt_cap_ie_r; // R6
      irq_set[pct_pkg::IRQ_WT_TOUT] = wt_term && wt_tout_ie_r; // R18
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_r <= pct_pkg::IRQ_RESET;
      end else if (wr && addr_ok && idx == pct_pkg::IDX_IRQ_CLEAR) begin
         irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | irq_set;
      end else begin
         irq_stat_r <= irq_stat_r | irq_set;
      end
   end

   assign irq = |(irq_stat_r & irq_en_r);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence bt_ctrl_write_one;
      wr && addr_ok && idx == pct_pkg::IDX_BT_CTRL && pwdata[pct_pkg::RUN_BIT];
   endsequence

   run_start_a: assert property (bt_ctrl_write_one |=> bt_run_r) // R1
      else $error("byte timer did not start after write");
   single_stop_a: assert property (bt_term && bt_single_r && !wr |=> !bt_run_r) // R2
      else $error("single pass did not stop at terminal count");
   modulo_keeps_a: assert property (bt_term && !bt_single_r && !wr |=> bt_run_r) // R2
      else $error("modulo mode stopped at terminal count");
   tout_set_a: assert property (bt_term |=> bt_tout_r) // R3
      else $error("timeout flag not set");
   tout_hold_a: assert property (bt_tout_r && !(wr && idx == pct_pkg::IDX_BT_CTRL) |=> bt_tout_r) // R3
      else $error("timeout flag lost without clear");
   // a new divider choice ends the spacing obligation
   div8_tick_a: assert property (byte_prescale_select_r == 2'h3 && tick // R5
      |=> (!tick || byte_prescale_select_r != 2'h3) [*7] ##1 (tick || byte_prescale_select_r != 2'h3))
      else $error("divide by eight spacing wrong");
   cap_irq_a: assert property (bt_cap_ev && bt_cap_ie_r |=> irq_stat_r[pct_pkg::IRQ_BT_CAP]) // R6
      else $error("capture interrupt not raised");
   no_tout_irq_a: assert property (!bt_tout_ie_r && !irq_stat_r[pct_pkg::IRQ_BT_TOUT]
      && !(wr && idx == pct_pkg::IDX_BT_CTRL) |=> !irq_stat_r[pct_pkg::IRQ_BT_TOUT]) // R7
      else $error("timeout interrupt raised while masked");
   pin_route_a: assert property (!byte_pin_route_r |-> byte_timer_pin == byte_port_data) // R8
      else $error("byte pin not a port output");
   idle_level_a: assert property (!bt_run_r && $past(!bt_run_r) && $stable(common_r)
      |-> bt_out_r == !common_r[pct_pkg::IDLE_LVL_BIT]) // R17
      else $error("idle byte output level wrong");
   word_irq_a: assert property (wt_term && wt_tout_ie_r |=> irq_stat_r[pct_pkg::IRQ_WT_TOUT] ##0 irq
      || !irq_en_r[pct_pkg::IRQ_WT_TOUT]) // R18
      else $error("word timeout interrupt missing");
   word_route_a: assert property (word_pin_route_r |-> word_timer_pin == wt_out_r) // R19
      else $error("word pin not carrying timer output");
   cap_ro_a: assert property (wr && idx == pct_pkg::IDX_BT_HI_CAP && !bt_cap_ev |=> $stable(bt_hi_cap_r)) // R11
      else $error("capture register changed by write");
endmodule : pct_timer

// ---- inc/pct_pkg.sv ----
// register map, field positions and reset values of the pulse counter timer
package pct_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_BT_CTRL = 6'h00;
   localparam logic [5:0] IDX_COMMON = 6'h01;
   localparam logic [5:0] IDX_WT_CTRL = 6'h02;
   localparam logic [5:0] IDX_BT_LO_HOLD = 6'h04;
   localparam logic [5:0] IDX_BT_HI_HOLD = 6'h05;
   localparam logic [5:0] IDX_WT_LO_HOLD = 6'h06;
   localparam logic [5:0] IDX_WT_HI_HOLD = 6'h07;
   localparam logic [5:0] IDX_WT_LO_CAP = 6'h08;
   localparam logic [5:0] IDX_WT_HI_CAP = 6'h09;
   localparam logic [5:0] IDX_BT_LO_CAP = 6'h0A;
   localparam logic [5:0] IDX_BT_HI_CAP = 6'h0B;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
   localparam logic [5:0] IDX_IRQ_CLEAR = 6'h11;
   localparam logic [5:0] IDX_IRQ_ENABLE = 6'h12;
   // timer control fields (byte and word timer share the layout)
   localparam int RUN_BIT = 7;
   localparam int SINGLE_BIT = 6;
   localparam int TOUT_BIT = 5;
   localparam int CLK_HI_BIT = 4;
   localparam int CLK_LO_BIT = 3;
   localparam int CAP_IE_BIT = 2;
   localparam int TOUT_IE_BIT = 1;
   localparam int ROUTE_BIT = 0;
   // common control fields
   localparam int DEMOD_BIT = 7;
   localparam int PIN_SEL_BIT = 5;
   localparam int EDGE_NEG_BIT = 4;
   localparam int FILT_HI_BIT = 3;
   localparam int FILT_LO_BIT = 2;
   localparam int IDLE_LVL_BIT = 1;
   // interrupt status bits
   localparam int IRQ_BT_TOUT = 0;
   localparam int IRQ_BT_CAP = 1;
   localparam int IRQ_WT_TOUT = 2;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] HOLD_RESET = 8'h00;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   // glitch filter least widths in pclk cycles for selections 00..11
   localparam logic [4:0] FILT_W0 = 5'h01;
   localparam logic [4:0] FILT_W1 = 5'h04;
   localparam logic [4:0] FILT_W2 = 5'h08;
   localparam logic [4:0] FILT_W3 = 5'h10;
   localparam logic [7:0] BT_TERMINAL_UP = 8'hFF;
endpackage : pct_pkg

// ---- verilog/pct_edge_filter.sv ----
// input synchroniser, glitch filter and edge detector
`timescale 1ns/100ps
module pct_edge_filter (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pins
   input wire logic edge_input_pin_a,
   input wire logic edge_input_pin_b,
   // selection
   input wire logic pin_sel,
   input wire logic edge_neg,
   input wire logic [1:0] width_sel,
   // results
   output logic level,
   output logic edge_pulse
);
   logic [1:0] sync_a_r;
   logic [1:0] sync_b_r;
   logic [4:0] run_r;
   logic [4:0] width;
   logic raw;
   logic level_r;
   logic pulse_r;

   // two flops per pin before anything looks at them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a_r <= 2'h0;
         sync_b_r <= 2'h0;
      end else begin
         sync_a_r <= {sync_a_r[0], edge_input_pin_a};
         sync_b_r <= {sync_b_r[0], edge_input_pin_b};
      end
   end

   assign raw = pin_sel ? sync_b_r[1] : sync_a_r[1]; // R15

   always_comb begin
      unique case (width_sel)
         2'h0: width = pct_pkg::FILT_W0;
         2'h1: width = pct_pkg::FILT_W1;
         2'h2: width = pct_pkg::FILT_W2;
         2'h3: width = pct_pkg::FILT_W3;
      endcase
   end

   // a new level is accepted only after it has stood for the chosen width
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_r <= 5'h00;
         level_r <= 1'b0;
      end else if (raw == level_r) begin
         run_r <= 5'h00;
      end else if (run_r + 5'h01 >= width) begin // R16
         run_r <= 5'h00;
         level_r <= raw;
      end else begin
         run_r <= run_r + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_r <= 1'b0;
      end else begin
         pulse_r <= (raw != level_r) && (run_r + 5'h01 >= width) && (raw != edge_neg); // R15
      end
   end

   assign level = level_r;
   assign edge_pulse = pulse_r;
endmodule : pct_edge_filter

// ---- test/pct_pulse_src.sv ----
// pulse waveform source standing on the far side of the edge input pins
`timescale 1ns/100ps
module pct_pulse_src (
   // clock
   input wire logic pclk,
   // pins
   output logic edge_input_pin_a,
   output logic edge_input_pin_b
);
   logic pin_v;

   initial begin
      edge_input_pin_a = 1'b0;
      edge_input_pin_b = 1'b0;
      pin_v = 1'b0;
   end

   // driven push-pull on both pins, so the unselected pin keeps a real level
   task automatic drive(input logic sel, input logic v, input int n);
      @(posedge pclk);
      if (sel) begin
         edge_input_pin_b <= v;
      end else begin
         edge_input_pin_a <= v;
      end
      repeat (n) @(posedge pclk);
   endtask

   // high h, low l, high h, then a long settle so the widest filter and capture finish
   task automatic burst(input logic sel, input int h, input int l);
      drive(sel, 1'b1, h - 1);
      drive(sel, 1'b0, l - 1);
      drive(sel, 1'b1, h - 1);
      drive(sel, 1'b0, 40);
   endtask
endmodule : pct_pulse_src

// ---- test/pct_timer_test.sv ----
// self-checking bench for the pulse counter timer
`timescale 1ns/100ps
module pct_timer_test;
   typedef struct {logic [31:0] e; logic [31:0] m; logic er;} pct_note_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, pin_a, pin_b, bpin, wpin;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv, c1, c2;
   logic [31:0] seed = 32'h91E0;
   logic [31:0] pd = 32'h0;
   int num_errors = 0;
   int total_checks = 0;
   int per[4];
   int n;
   pct_note_t notes[$];
   pct_note_t cur;
   `define CHK(nm, ex, g) begin total_checks++; if ((g) !== (ex)) begin num_errors++; $display("BAD %s exp %h got %h", nm, ex, g); end end

   pct_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .edge_input_pin_a(pin_a), .edge_input_pin_b(pin_b), .byte_port_data(pd[0]), .word_port_data(pd[7]),
      .byte_timer_pin(bpin), .word_timer_pin(wpin), .irq(irq));
   pct_pulse_src src (.pclk(pclk), .edge_input_pin_a(pin_a), .edge_input_pin_b(pin_b));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // port output values wander so an unrouted pin is seen to follow them
   always @(posedge pclk) begin
      pd <= rnd();
   end

   // oldest note against each completed transfer
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         cur = notes.pop_front();
         `CHK("prdata", cur.e & cur.m, prdata & cur.m)
         `CHK("pslverr", cur.er, pslverr)
      end
   end

   task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d, input logic [31:0] e,
                      input logic [31:0] m, input logic er, output logic [31:0] q);
      notes.push_back('{e, m, er});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [5:0] i, input logic [7:0] d);
      apb(1'b1, i, {24'h0, d}, 32'h0, 32'h0, 1'b0, rv);
   endtask : wr

   task automatic rd(input logic [5:0] i, input logic [7:0] e, input logic [7:0] m);
      apb(1'b0, i, 32'h0, {24'h0, e}, {24'h0, m}, 1'b0, rv);
   endtask : rd

   task automatic wait_irq(input int lim);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(negedge pclk);
         n++;
      end
      `CHK("irq", 1'b1, irq)
   endtask : wait_irq

   // cycles until the byte pin changes level
   task automatic to_toggle(output int k);
      logic v;
      @(negedge pclk);
      v = bpin;
      k = 0;
      while (bpin === v && k < 3000) begin
         @(negedge pclk);
         k++;
      end
   endtask : to_toggle

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (60000) @(posedge pclk);
      num_errors++;
      stop_test();
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      `CHK("irq", 1'b0, irq)
      `CHK("byte pin", pd[0], bpin)
      `CHK("word pin", pd[7], wpin)
      rd(pct_pkg::IDX_BT_CTRL, pct_pkg::CTRL_RESET, 8'hFF);
      rd(pct_pkg::IDX_IRQ_STATUS, 8'h00, 8'h07);
      apb(1'b0, 6'h03, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1, rv);
      for (int i = 4; i < 8; i++) begin
         c1 = rnd();
         wr(6'(i), c1[7:0]);
         rd(6'(i), c1[7:0], 8'hFF);
      end
      for (int i = 8; i < 12; i++) begin
         apb(1'b0, 6'(i), 32'h0, 32'h0, 32'h0, 1'b0, c1);
         wr(6'(i), ~c1[7:0]);
         rd(6'(i), c1[7:0], 8'hFF);
      end
      // idle transmit level follows the inverse of the common idle bit
      wr(pct_pkg::IDX_COMMON, 8'h00);
      wr(pct_pkg::IDX_BT_CTRL, 8'h21);
      @(negedge pclk);
      `CHK("idle out", 1'b1, bpin)
      wr(pct_pkg::IDX_COMMON, 8'h02);
      // the idle level follows one clock after the common write
      repeat (2) @(negedge pclk);
      `CHK("idle out", 1'b0, bpin)
      // single pass without its interrupt, then reload with it
      wr(pct_pkg::IDX_BT_LO_HOLD, 8'h03);
      wr(pct_pkg::IDX_BT_HI_HOLD, 8'h03);
      wr(pct_pkg::IDX_IRQ_ENABLE, 8'h01);
      wr(pct_pkg::IDX_BT_CTRL, 8'hC0);
      repeat (100) @(posedge pclk);
      rd(pct_pkg::IDX_BT_CTRL, 8'h60, 8'hE0);
      rd(pct_pkg::IDX_IRQ_STATUS, 8'h00, 8'h01);
      `CHK("irq", 1'b0, irq)
      wr(pct_pkg::IDX_BT_CTRL, 8'h00);
      rd(pct_pkg::IDX_BT_CTRL, 8'h20, 8'h20);
      wr(pct_pkg::IDX_BT_CTRL, 8'h20);
      rd(pct_pkg::IDX_BT_CTRL, 8'h00, 8'h20);
      wr(pct_pkg::IDX_BT_CTRL, 8'h82);
      wait_irq(200);
      rd(pct_pkg::IDX_BT_CTRL, 8'hA0, 8'hE0);
      rd(pct_pkg::IDX_IRQ_STATUS, 8'h01, 8'h01);
      wr(pct_pkg::IDX_IRQ_ENABLE, 8'h00);
      @(negedge pclk);
      `CHK("irq masked", 1'b0, irq)
      wr(pct_pkg::IDX_BT_CTRL, 8'h20);
      wr(pct_pkg::IDX_IRQ_CLEAR, 8'h07);
      wr(pct_pkg::IDX_IRQ_ENABLE, 8'h07);
      @(negedge pclk);
      `CHK("irq cleared", 1'b0, irq)
      // toggle spacing scales with the divider; the first, partial tick is skipped
      for (int s = 0; s < 4; s++) begin
         wr(pct_pkg::IDX_BT_CTRL, 8'h81 | 8'(s << 3));
         to_toggle(per[s]);
         to_toggle(per[s]);
         wr(pct_pkg::IDX_BT_CTRL, 8'h20);
      end
      // to_toggle counts one negedge short of the half period; holds of 3 give 4 ticks
      for (int s = 0; s < 4; s++) begin
         `CHK("period", 4 * (1 << s), per[s] + 1)
      end
      // demodulation: low widths differ by exactly 20 counts
      wr(pct_pkg::IDX_COMMON, 8'h80);
      wr(pct_pkg::IDX_BT_CTRL, 8'hA4);
      src.burst(1'b0, 20, 30);
      apb(1'b0, pct_pkg::IDX_BT_LO_CAP, 32'h0, 32'h0, 32'h0, 1'b0, c1);
      src.burst(1'b0, 20, 50);
      apb(1'b0, pct_pkg::IDX_BT_LO_CAP, 32'h0, 32'h0, 32'h0, 1'b0, c2);
      `CHK("low count", 8'd20, 8'(c2[7:0] - c1[7:0]))
      rd(pct_pkg::IDX_IRQ_STATUS, 8'h02, 8'h02);
      wr(pct_pkg::IDX_IRQ_CLEAR, 8'h02);
      wr(pct_pkg::IDX_COMMON, 8'h8C);
      src.burst(1'b0, 8, 8);
      rd(pct_pkg::IDX_IRQ_STATUS, 8'h00, 8'h02);
      wr(pct_pkg::IDX_COMMON, 8'hB0);
      src.burst(1'b0, 30, 30);
      rd(pct_pkg::IDX_IRQ_STATUS, 8'h00, 8'h02);
      src.burst(1'b1, 30, 30);
      rd(pct_pkg::IDX_IRQ_STATUS, 8'h02, 8'h02);
      wr(pct_pkg::IDX_BT_CTRL, 8'h20);
      wr(pct_pkg::IDX_IRQ_CLEAR, 8'h07);
      // word timer timeout interrupt
      wr(pct_pkg::IDX_WT_LO_HOLD, 8'h05);
      wr(pct_pkg::IDX_WT_HI_HOLD, 8'h00);
      wr(pct_pkg::IDX_WT_CTRL, 8'hA3);
      wait_irq(300);
      // holds of 5 toggle the routed word pin every 6 clocks
      @(negedge pclk);
      c1[0] = wpin;
      repeat (6) @(negedge pclk);
      `CHK("word pin", ~c1[0], wpin)
      rd(pct_pkg::IDX_IRQ_STATUS, 8'h04, 8'h04);
      wr(pct_pkg::IDX_WT_CTRL, 8'h20);
      stop_test();
   end
endmodule : pct_timer_test
